/* pkg/pad_irq_pkg.sv */
// package: pad interrupt unit constants, register map and carriers
package pad_irq_pkg;

  // pad count and register port widths
  localparam int NUM_PADS = 16;
  localparam int ADDR_W   = 3;

  typedef logic [NUM_PADS-1:0] pad_vec_t;
  typedef logic [ADDR_W-1:0]   reg_addr_t;

  // register indexes on the plain register port
  localparam reg_addr_t OFS_MASK       = 3'h0;
  localparam reg_addr_t OFS_POLARITY   = 3'h1;
  localparam reg_addr_t OFS_PAD_LEVEL  = 3'h2;
  localparam reg_addr_t OFS_PAD_TERM   = 3'h3;
  localparam reg_addr_t OFS_EVT_STATUS = 3'h4;
  localparam reg_addr_t OFS_EVT_MASK   = 3'h5;

  // polarity encoding: zero selects rising / high-active
  localparam logic POL_RISING  = 1'h0;
  localparam logic POL_FALLING = 1'h1;

  // values after reset
  localparam pad_vec_t MASK_RST       = 16'h0000;
  localparam pad_vec_t POLARITY_RST   = {NUM_PADS{POL_RISING}};
  localparam pad_vec_t EVT_STATUS_RST = 16'h0000;
  localparam pad_vec_t EVT_MASK_RST   = 16'h0000;
  localparam pad_vec_t RD_DATA_RST    = 16'h0000;
  localparam pad_vec_t SYNC_RST       = 16'h0000;

  // one register port request
  typedef struct packed {
    reg_addr_t addr;
    pad_vec_t  wdata;
    logic      wr;
    logic      rd;
  } reg_req_s;

endpackage : pad_irq_pkg

/* logic/pad_sync.sv */
// module: three-stage pad synchroniser with agreement filter
`timescale 1ns/100ps
module pad_sync
  import pad_irq_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire logic     nrst,
  input  wire pad_vec_t pad_async,
  output pad_vec_t      pad_level
);

  pad_vec_t s1_ff;
  pad_vec_t s2_ff;
  pad_vec_t s3_ff;
  pad_vec_t level_ff;
  pad_vec_t nxt_level;

  // take a bit only once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < NUM_PADS; i++)
    begin
      nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : level_ff[i];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_ff    <= SYNC_RST;
      s2_ff    <= SYNC_RST;
      s3_ff    <= SYNC_RST;
      level_ff <= SYNC_RST;
    end
    else
    begin
      s1_ff    <= pad_async;
      s2_ff    <= s1_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign pad_level = level_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_sync_agree;
    !$stable(level_ff) |-> ($past(s2_ff) == $past(s3_ff)) && (level_ff == $past(s3_ff));
  endproperty
  a_sync_agree: assert property (p_sync_agree)
    else $error("pad level changed without stage agreement");

endmodule : pad_sync

/* logic/pad_interrupt_unit.sv */
// module: pad interrupt unit, per-pad mask and polarity, combined request
// Summary of operation
// - every pad is an interrupt source, any function
// - per-pad mask, disabled after reset
// - per-pad polarity, rising after reset
// - pad term is mask and (polarity xor pad)
// - combined output is or of all terms
// - mask and polarity in two writable registers
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module pad_interrupt_unit
  import pad_irq_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire logic     nrst,
  input  wire pad_vec_t pad_in,
  input  wire reg_req_s reg_req,
  output pad_vec_t      rd_data,
  output logic          combined_pad_irq,
  output logic          status_irq
);

  // register port write decode
  function automatic logic wr_hit(input reg_req_s req, input reg_addr_t ofs);
    return req.wr && (req.addr == ofs);
  endfunction : wr_hit

  // write one to clear, hardware set wins
  function automatic pad_vec_t w1c_set(input pad_vec_t cur, input pad_vec_t clr,
                                       input pad_vec_t set);
    return (cur & ~clr) | set;
  endfunction : w1c_set

  pad_vec_t pad_level;
  pad_vec_t mask_ff;
  pad_vec_t polarity_ff;
  pad_vec_t term_ff;
  pad_vec_t evt_status_ff;
  pad_vec_t evt_mask_ff;
  pad_vec_t rd_data_ff;
  logic     combined_ff;
  logic     status_irq_ff;

  pad_vec_t nxt_mask;
  pad_vec_t nxt_polarity;
  pad_vec_t nxt_term;
  pad_vec_t nxt_evt_status;
  pad_vec_t nxt_evt_mask;
  pad_vec_t nxt_rd_data;
  logic     nxt_combined;
  logic     nxt_status_irq;
  pad_vec_t term_rise;

  // every pad, whatever its function, feeds the synchroniser
  pad_sync pad_sync_i (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .pad_async (pad_in),
    .pad_level (pad_level)
  );

  // control registers
  always_comb
  begin
    nxt_mask     = mask_ff;
    nxt_polarity = polarity_ff;
    nxt_evt_mask = evt_mask_ff;
    if (wr_hit(reg_req, OFS_MASK))
    begin
      nxt_mask = reg_req.wdata;
    end
    if (wr_hit(reg_req, OFS_POLARITY))
    begin
      nxt_polarity = reg_req.wdata;
    end
    if (wr_hit(reg_req, OFS_EVT_MASK))
    begin
      nxt_evt_mask = reg_req.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mask_ff     <= MASK_RST;
      polarity_ff <= POLARITY_RST;
      evt_mask_ff <= EVT_MASK_RST;
    end
    else
    begin
      mask_ff     <= nxt_mask;
      polarity_ff <= nxt_polarity;
      evt_mask_ff <= nxt_evt_mask;
    end
  end

  // pad terms and combined request
  always_comb
  begin
    nxt_term     = mask_ff & (polarity_ff ^ pad_level);
    nxt_combined = |nxt_term;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      term_ff     <= '0;
      combined_ff <= 1'h0;
    end
    else
    begin
      term_ff     <= nxt_term;
      combined_ff <= nxt_combined;
    end
  end

  // sticky events on each term going active, masked status interrupt
  always_comb
  begin
    term_rise      = nxt_term & ~term_ff;
    nxt_evt_status = evt_status_ff;
    if (wr_hit(reg_req, OFS_EVT_STATUS))
    begin
      nxt_evt_status = w1c_set(evt_status_ff, reg_req.wdata, term_rise);
    end
    else
    begin
      nxt_evt_status = evt_status_ff | term_rise;
    end
    nxt_status_irq = |(nxt_evt_status & nxt_evt_mask);
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      evt_status_ff <= EVT_STATUS_RST;
      status_irq_ff <= 1'h0;
    end
    else
    begin
      evt_status_ff <= nxt_evt_status;
      status_irq_ff <= nxt_status_irq;
    end
  end

  // read data, valid only in the cycle after the read strobe
  always_comb
  begin
    nxt_rd_data = RD_DATA_RST;
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        OFS_MASK:       nxt_rd_data = mask_ff;
        OFS_POLARITY:   nxt_rd_data = polarity_ff;
        OFS_PAD_LEVEL:  nxt_rd_data = pad_level;
        OFS_PAD_TERM:   nxt_rd_data = term_ff;
        OFS_EVT_STATUS: nxt_rd_data = evt_status_ff;
        OFS_EVT_MASK:   nxt_rd_data = evt_mask_ff;
        default:        nxt_rd_data = RD_DATA_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data_ff <= RD_DATA_RST;
    end
    else
    begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data          = rd_data_ff;
  assign combined_pad_irq = combined_ff;
  assign status_irq       = status_irq_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // pad stable long enough is seen on every bit
  property p_all_pads;
    $stable(pad_in) [*5] |-> pad_level == pad_in;
  endproperty
  a_all_pads: assert property (p_all_pads)
    else $error("pad level does not follow a stable pad input");

  property p_mask_hold;
    !$stable(mask_ff) |-> $past(reg_req.wr) && ($past(reg_req.addr) == OFS_MASK);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("mask changed without a mask write");

  property p_pol_hold;
    !$stable(polarity_ff) |-> $past(reg_req.wr) && ($past(reg_req.addr) == OFS_POLARITY);
  endproperty
  a_pol_hold: assert property (p_pol_hold)
    else $error("polarity changed without a polarity write");

  property p_term;
    term_ff == $past(mask_ff & (polarity_ff ^ pad_level));
  endproperty
  a_term: assert property (p_term)
    else $error("pad term differs from mask and polarity of pad");

  property p_combined;
    combined_pad_irq == (term_ff != '0);
  endproperty
  a_combined: assert property (p_combined)
    else $error("combined request not the or of pad terms");

  property p_regs_written;
    reg_req.wr && (reg_req.addr == OFS_MASK || reg_req.addr == OFS_POLARITY)
      |=> (($past(reg_req.addr) == OFS_MASK) ? mask_ff : polarity_ff) == $past(reg_req.wdata);
  endproperty
  a_regs_written: assert property (p_regs_written)
    else $error("mask or polarity write not stored");

  property p_mask_write;
    reg_req.wr && reg_req.addr == OFS_MASK |=> mask_ff == $past(reg_req.wdata);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask write not stored");

  property p_sync_delay;
    !$stable(pad_level) |-> $past(pad_in, 4) == pad_level;
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("pad level change not four cycles after the pad");

  property p_set_wins;
    (term_rise != '0) |=> (evt_status_ff & $past(term_rise)) == $past(term_rise);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("term event lost in status");

  property p_status_irq;
    ##1 status_irq == ((evt_status_ff & evt_mask_ff) != '0);
  endproperty
  a_status_irq: assert property (p_status_irq)
    else $error("status interrupt not the masked status");

  property p_rd_one_cycle;
    !reg_req.rd |=> rd_data == '0;
  endproperty
  a_rd_one_cycle: assert property (p_rd_one_cycle)
    else $error("read data outside the answer cycle");

  property p_rd_answer;
    reg_req.rd && reg_req.addr == OFS_EVT_STATUS |=> rd_data == $past(evt_status_ff);
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read data not the addressed register");

  c_combined_rise: cover property ($rose(combined_pad_irq));
  c_falling_pad:   cover property ((polarity_ff != '0) ##1 $rose(combined_pad_irq));
  c_status_irq:    cover property ($rose(status_irq) ##[1:20] $fell(status_irq));
  c_rd_status:     cover property (reg_req.rd && reg_req.addr == OFS_EVT_STATUS);

endmodule : pad_interrupt_unit

/* verif/pad_source_model.sv */
// partner model: external pad drivers, changing off the clock grid
`timescale 1ns/100ps
module pad_source_model
  import pad_irq_pkg::*;
(
  input  wire pad_vec_t level_req,
  output wire pad_vec_t pad_out
);
  // pads are asynchronous to ref_clk
  assign #13 pad_out = level_req;
endmodule : pad_source_model

/* verif/pad_interrupt_unit_tb.sv */
// testbench: pad interrupt unit scenarios
`timescale 1ns/100ps
module pad_interrupt_unit_tb
  import pad_irq_pkg::*;
;
  logic     ref_clk;
  logic     nrst;
  reg_req_s reg_req;
  pad_vec_t level_req;
  pad_vec_t pad_in;
  pad_vec_t rd_data;
  logic     combined_pad_irq;
  logic     status_irq;
  int       mismatches  = 0;
  int       check_count = 0;
  int       cycles      = 0;

  pad_source_model pad_source_model_i (.level_req(level_req), .pad_out(pad_in));
  pad_interrupt_unit pad_interrupt_unit_i (.ref_clk(ref_clk), .nrst(nrst), .pad_in(pad_in),
    .reg_req(reg_req), .rd_data(rd_data), .combined_pad_irq(combined_pad_irq),
    .status_irq(status_irq));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic check(input pad_vec_t got, input pad_vec_t exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic reg_write(input reg_addr_t a, input pad_vec_t d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input reg_addr_t a, input pad_vec_t exp);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    #1;
    check(rd_data, exp, "register read");
  endtask : reg_check

  task automatic irq_check(input logic exp);
    repeat (7) @(posedge ref_clk);
    #1;
    check(pad_vec_t'(combined_pad_irq), pad_vec_t'(exp), "combined irq");
  endtask : irq_check

  task automatic t_reset;
    reg_check(OFS_MASK, 16'h0000);
    reg_check(OFS_POLARITY, 16'h0000);
    reg_check(3'h6, 16'h0000);
    level_req <= 16'hffff;
    irq_check(1'b0);
    reg_check(OFS_PAD_LEVEL, 16'hffff);
    level_req <= 16'h0000;
  endtask : t_reset

  task automatic t_each_pad;
    for (int i = 0; i < NUM_PADS; i++)
    begin
      reg_write(OFS_MASK, 16'h0001 << i);
      level_req <= 16'h0001 << i;
      irq_check(1'b1);
      reg_check(OFS_PAD_TERM, 16'h0001 << i);
      level_req <= ~(16'h0001 << i);
      irq_check(1'b0);
    end
    level_req <= 16'h0000;
  endtask : t_each_pad

  task automatic t_polarity;
    reg_write(OFS_MASK, 16'hffff);
    reg_write(OFS_POLARITY, 16'h00f0);
    reg_check(OFS_POLARITY, 16'h00f0);
    irq_check(1'b1);
    reg_check(OFS_PAD_TERM, 16'h00f0);
    level_req <= 16'h00f0;
    irq_check(1'b0);
    level_req <= 16'h0f0f;
    irq_check(1'b1);
    reg_check(OFS_PAD_TERM, 16'h0fff);
    reg_write(OFS_MASK, 16'hf000);
    irq_check(1'b0);
    reg_write(OFS_POLARITY, 16'h0000);
    reg_write(OFS_MASK, 16'h0001);
    level_req <= 16'h0000;
    irq_check(1'b0);
  endtask : t_polarity

  task automatic t_sync_events;
    reg_write(OFS_EVT_STATUS, 16'hffff);
    reg_check(OFS_EVT_STATUS, 16'h0000);
    reg_write(OFS_EVT_MASK, 16'h0001);
    @(posedge ref_clk);
    level_req <= 16'h0001;
    repeat (4) @(posedge ref_clk);
    #1;
    check(pad_vec_t'(combined_pad_irq), 16'h0000, "sync early");
    @(posedge ref_clk);
    #1;
    check(pad_vec_t'(combined_pad_irq), 16'h0001, "sync on time");
    irq_check(1'b1);
    reg_check(OFS_EVT_STATUS, 16'h0001);
    check(pad_vec_t'(status_irq), 16'h0001, "status irq");
    reg_write(OFS_EVT_MASK, 16'h0000);
    repeat (2) @(posedge ref_clk);
    #1;
    check(pad_vec_t'(status_irq), 16'h0000, "status irq masked");
    reg_write(OFS_EVT_MASK, 16'h0001);
    reg_write(OFS_EVT_STATUS, 16'h0001);
    repeat (2) @(posedge ref_clk);
    #1;
    check(pad_vec_t'(status_irq), 16'h0000, "status irq cleared");
    reg_check(OFS_EVT_STATUS, 16'h0000);
  endtask : t_sync_events

  initial
  begin
    nrst = 1'b0;
    reg_req = '0;
    level_req = '0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_each_pad();
    t_polarity();
    t_sync_events();
    print_verdict();
  end
endmodule : pad_interrupt_unit_tb
